// ---- src/scsrg_defines.vh ----
`ifndef SCSRG_DEFINES_VH
`define SCSRG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCSRG_OFS_PLL_FACTOR     8'h04
`define SCSRG_OFS_SOURCE_ASSIGN  8'h0C
`define SCSRG_OFS_RATE_PRESCALE  8'h10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCSRG_RST_PLL_FACTOR     32'h00030032
`define SCSRG_RST_SOURCE_ASSIGN  32'h00000000
`define SCSRG_RST_RATE_PRESCALE  32'h00000005

// ----------------------------------------------------------------
// writable masks, reserved bits read zero
// ----------------------------------------------------------------
`define SCSRG_MSK_PLL_FACTOR     32'h00FFFFFF
`define SCSRG_MSK_SOURCE_ASSIGN  32'h000000FF
`define SCSRG_MSK_RATE_PRESCALE  32'h000001FF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCSRG_VCO_LSB            0
`define SCSRG_VCO_MSB            11
`define SCSRG_REF_LSB            12
`define SCSRG_REF_MSB            23
`define SCSRG_G0_LSB             0
`define SCSRG_G0_MSB             3
`define SCSRG_G1_LSB             4
`define SCSRG_G1_MSB             7
`define SCSRG_NDIV_LSB           0
`define SCSRG_NDIV_MSB           8

// ----------------------------------------------------------------
// source codes
// ----------------------------------------------------------------
`define SCSRG_SRC_INTERNAL       4'h0
`define SCSRG_SRC_EXT_GEN        4'h4
`define SCSRG_SRC_EXT_DIRECT     4'h5
`define SCSRG_SRC_DISABLED       4'h6

// ----------------------------------------------------------------
// timing counts, in converter clock periods
// ----------------------------------------------------------------
`define SCSRG_SETTLE_PERIODS     8'h8C
`define SCSRG_HS_CLKS_PER_SAMPLE 10'h100
`define SCSRG_HR_CLKS_PER_SAMPLE 10'h200

`endif

// ---- src/scsrg_clkdiv.v ----
`timescale 1ns/1ns
`default_nettype none

module scsrg_clkdiv #(
  parameter W = 9
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         resetn,
  // source edges and divisor
  input  wire         src_tick,
  input  wire [W-1:0] ndiv,
  // divided output
  output reg          half_clk
);

  reg  [W-1:0] cnt;
  wire [W-1:0] last = (ndiv == {W{1'b0}}) ? {W{1'b0}} : ndiv - {{(W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // prescale then 2:1 toggle
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt      <= {W{1'b0}};
      half_clk <= 1'b0;
    end else if (src_tick) begin
      if (cnt >= last) begin
        cnt      <= {W{1'b0}};
        half_clk <= ~half_clk;
      end else begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // scsrg_clkdiv

`default_nettype wire

// ---- src/scsrg_top.v ----
// Summary of operation
// - group 0 code picks source for both
// - codes 0 internal, 4 external, 5 direct
// - group 1 code 6 disables, 0 none
// - disabled groups write nothing to buffer
// - disabled group 0 disables both groups
// - sample rate is clock over Ndiv times 512/1024
// - prescale bits 8..0, values 1 to 300
// - 2:1 stage gives 50 percent duty
// - mode change resets buffer, 140 periods unsettled
// - multiplier bits 11..0, read/write, 25-300
// - divider bits 23..12, read/write, 25-300
// - generator locks to 49.152 MHz reference
// - direct external clock passes unmodified when clock_target is set, else adc_clk stops
// - mode bit still drives converters when direct
// - two equal groups of channels
// - register value or mode change starts synchronization
`timescale 1ns/1ns
`default_nettype none
`include "scsrg_defines.vh"

module scsrg_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // board control word bits
  input  wire        high_speed_mode,
  input  wire        clock_target,
  // clock inputs, sampled on ref_clk
  input  wire        gen_clk_in,
  input  wire        ext_clk_in,
  // conversion results per group
  input  wire        conv_valid_g0,
  input  wire        conv_valid_g1,
  // to pll
  output reg  [11:0] pll_vco_factor,
  output reg  [11:0] pll_ref_factor,
  // to converters and buffer
  output reg         adc_clk,
  output reg         adc_hs_mode,
  output reg         sample_strobe,
  output reg         buf_wr_g0,
  output reg         buf_wr_g1,
  output reg         buf_reset,
  output reg         channels_settled,
  output reg         sync_start,
  output reg         group0_enabled,
  output reg         group1_enabled,
  output reg         source_invalid
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [31:0] pll_factor_control;
  reg  [31:0] sample_source_assign;
  reg  [31:0] rate_prescale;
  wire [31:0] wmask_pll = reg_wdata & `SCSRG_MSK_PLL_FACTOR;
  wire [31:0] wmask_src = reg_wdata & `SCSRG_MSK_SOURCE_ASSIGN;
  wire [31:0] wmask_div = reg_wdata & `SCSRG_MSK_RATE_PRESCALE;
  wire        wr_pll    = reg_wr && (reg_addr == `SCSRG_OFS_PLL_FACTOR);
  wire        wr_src    = reg_wr && (reg_addr == `SCSRG_OFS_SOURCE_ASSIGN);
  wire        wr_div    = reg_wr && (reg_addr == `SCSRG_OFS_RATE_PRESCALE);
  wire        chg_regs  = (wr_pll && (wmask_pll != pll_factor_control))
                       || (wr_src && (wmask_src != sample_source_assign))
                       || (wr_div && (wmask_div != rate_prescale));

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pll_factor_control   <= `SCSRG_RST_PLL_FACTOR;
      sample_source_assign <= `SCSRG_RST_SOURCE_ASSIGN;
      rate_prescale        <= `SCSRG_RST_RATE_PRESCALE;
    end else begin
      if (wr_pll) begin
        pll_factor_control <= wmask_pll;
      end
      if (wr_src) begin
        sample_source_assign <= wmask_src;
      end
      if (wr_div) begin
        rate_prescale <= wmask_div;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SCSRG_OFS_PLL_FACTOR:    reg_rdata <= pll_factor_control;
        `SCSRG_OFS_SOURCE_ASSIGN: reg_rdata <= sample_source_assign;
        `SCSRG_OFS_RATE_PRESCALE: reg_rdata <= rate_prescale;
        default:                  reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  wire [3:0] g0_code = sample_source_assign[`SCSRG_G0_MSB:`SCSRG_G0_LSB];
  wire [3:0] g1_code = sample_source_assign[`SCSRG_G1_MSB:`SCSRG_G1_LSB];
  wire       sel_int = (g0_code == `SCSRG_SRC_INTERNAL);
  wire       sel_ext = (g0_code == `SCSRG_SRC_EXT_GEN);
  wire       sel_dir = (g0_code == `SCSRG_SRC_EXT_DIRECT);
  wire       g0_on   = sel_int || sel_ext || sel_dir;
  wire       g1_on   = g0_on && (g1_code != `SCSRG_SRC_DISABLED);
  wire       direct  = sel_dir && clock_target;

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  reg gen_q;
  reg ext_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gen_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      gen_q <= gen_clk_in;
      ext_q <= ext_clk_in;
    end
  end

  wire gen_tick = gen_clk_in && !gen_q;
  wire ext_tick = ext_clk_in && !ext_q;
  wire src_tick = sel_ext ? ext_tick : (sel_int ? gen_tick : 1'b0);

  // ----------------------------------------------------------------
  // prescaler and 2:1 stage
  // ----------------------------------------------------------------
  wire half_clk;

  scsrg_clkdiv #(
    .W (9)
  ) u_div (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .src_tick (src_tick),
    .ndiv     (rate_prescale[`SCSRG_NDIV_MSB:`SCSRG_NDIV_LSB]),
    .half_clk (half_clk)
  );

  wire next_adc_clk = direct ? ext_clk_in : half_clk;
  wire adc_rise     = next_adc_clk && !adc_clk;

  // ----------------------------------------------------------------
  // sample strobe, 256 or 512 converter clocks per sample
  // ----------------------------------------------------------------
  reg  [9:0] smp_cnt;
  wire [9:0] smp_last = (high_speed_mode ? `SCSRG_HS_CLKS_PER_SAMPLE
                                         : `SCSRG_HR_CLKS_PER_SAMPLE) - 10'h001;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_clk       <= 1'b0;
      smp_cnt       <= 10'h000;
      sample_strobe <= 1'b0;
    end else begin
      adc_clk       <= next_adc_clk;
      sample_strobe <= 1'b0;
      if (adc_rise) begin
        if (smp_cnt >= smp_last) begin
          smp_cnt       <= 10'h000;
          sample_strobe <= 1'b1;
        end else begin
          smp_cnt <= smp_cnt + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode change settling
  // ----------------------------------------------------------------
  reg  [7:0] settle_cnt;
  wire       mode_chg = (high_speed_mode != adc_hs_mode);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_hs_mode      <= 1'b0;
      settle_cnt       <= 8'h00;
      buf_reset        <= 1'b0;
      channels_settled <= 1'b0;
    end else begin
      adc_hs_mode <= high_speed_mode;
      if (mode_chg) begin
        settle_cnt       <= `SCSRG_SETTLE_PERIODS;
        buf_reset        <= 1'b1;
        channels_settled <= 1'b0;
      end else if (settle_cnt != 8'h00) begin
        buf_reset <= 1'b0;
        if (adc_rise) begin
          settle_cnt <= settle_cnt - 8'h01;
        end
      end else begin
        buf_reset        <= 1'b0;
        channels_settled <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // group gating, sync request, status outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      buf_wr_g0      <= 1'b0;
      buf_wr_g1      <= 1'b0;
      sync_start     <= 1'b0;
      group0_enabled <= 1'b0;
      group1_enabled <= 1'b0;
      source_invalid <= 1'b0;
      pll_vco_factor <= 12'h000;
      pll_ref_factor <= 12'h000;
    end else begin
      buf_wr_g0      <= conv_valid_g0 && g0_on;
      buf_wr_g1      <= conv_valid_g1 && g1_on;
      sync_start     <= chg_regs || mode_chg;
      group0_enabled <= g0_on;
      group1_enabled <= g1_on;
      source_invalid <= !g0_on;
      pll_vco_factor <= pll_factor_control[`SCSRG_VCO_MSB:`SCSRG_VCO_LSB];
      pll_ref_factor <= pll_factor_control[`SCSRG_REF_MSB:`SCSRG_REF_LSB];
    end
  end

endmodule // scsrg_top

`default_nettype wire

// ---- tb/scsrg_clk_src_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module scsrg_clk_src_model (
  // clock and control
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  // generated clock
  output var  logic       clk_out
);
  logic [7:0] cnt = 8'h00;
  initial clk_out = 1'b0;
  // stands low while stopped, toggles every half cycles
  always @(posedge ref_clk) begin
    #1;
    if (!run) begin
      clk_out = 1'b0;
      cnt = 8'h00;
    end else if (cnt >= half - 8'h01) begin
      clk_out = ~clk_out;
      cnt = 8'h00;
    end else begin
      cnt = cnt + 8'h01;
    end
  end
endmodule // scsrg_clk_src_model
`default_nettype wire

// ---- tb/scsrg_top_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module scsrg_top_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // mode and status
  input wire logic        high_speed_mode,
  input wire logic        conv_valid_g1,
  input wire logic [11:0] pll_vco_factor,
  input wire logic [11:0] pll_ref_factor,
  input wire logic        adc_clk,
  input wire logic        adc_hs_mode,
  input wire logic        buf_wr_g1,
  input wire logic        buf_reset,
  input wire logic        channels_settled,
  input wire logic        sync_start,
  input wire logic        group0_enabled,
  input wire logic        group1_enabled,
  input wire logic        source_invalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // converter clock rises since the last buffer reset
  // ----------------------------------------------------------------
  logic [8:0] rises;
  logic       armed;
  logic       adc_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rises <= 9'h000;
      armed <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      adc_q <= adc_clk;
      if (buf_reset) begin
        rises <= 9'h000;
        armed <= 1'b1;
      end else if (adc_clk && !adc_q && !channels_settled) begin
        rises <= rises + 9'h001;
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_chg; high_speed_mode != adc_hs_mode; endsequence
  sequence s_rst; buf_reset && sync_start && !channels_settled ##1 !buf_reset; endsequence
  property p_mode; s_chg |=> s_rst; endproperty
  a_mode: assert property (p_mode) else $error("mode change response");
  property p_settle; $rose(channels_settled) && armed |-> rises >= 9'h08B && rises <= 9'h08D; endproperty
  a_settle: assert property (p_settle) else $error("settle length");
  property p_g1; !group0_enabled |-> !group1_enabled; endproperty
  a_g1: assert property (p_g1) else $error("group 1 on with group 0 off");
  property p_inv; $past(resetn) |-> source_invalid == !group0_enabled; endproperty
  a_inv: assert property (p_inv) else $error("invalid flag");
  property p_bw; buf_wr_g1 |-> $past(conv_valid_g1) && group1_enabled; endproperty
  a_bw: assert property (p_bw) else $error("buffer write gating");
  property p_src; reg_rd && reg_addr == 8'h0C |=> reg_rdata[31:8] == 24'h000000; endproperty
  a_src: assert property (p_src) else $error("source reserved bits");
  property p_div; reg_rd && reg_addr == 8'h10 |=> reg_rdata[31:9] == 23'h000000; endproperty
  a_div: assert property (p_div) else $error("prescale reserved bits");
  property p_pll;
    $past(resetn) && reg_rd && !reg_wr && !$past(reg_wr) && reg_addr == 8'h04
      |=> reg_rdata == {8'h00, $past(pll_ref_factor), $past(pll_vco_factor)};
  endproperty
  a_pll: assert property (p_pll) else $error("pll factor readback");
endmodule // scsrg_top_chk
bind scsrg_top scsrg_top_chk chk (.*);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        high_speed_mode = 1'b0, clock_target = 1'b0, rd_q = 1'b0, rd_q2 = 1'b0;
  logic        conv_valid_g0 = 1'b0, conv_valid_g1 = 1'b0, ok;
  logic [7:0]  reg_addr = 8'h00, ext_half = 8'h03;
  logic [31:0] reg_wdata = 32'h00000000, seed = 32'h0000A028, d, exp_q[$];
  wire  [31:0] reg_rdata;
  wire  [11:0] pll_vco_factor, pll_ref_factor;
  wire         gen_clk_in, ext_clk_in, adc_clk, adc_hs_mode, sample_strobe, buf_wr_g0;
  wire         buf_wr_g1, buf_reset, channels_settled, sync_start, group0_enabled;
  wire         group1_enabled, source_invalid;
  int          miscompares = 0, comparisons = 0, p, h, g;
  int          cd[5] = '{0, 4, 5, 5, 6}, nd[5] = '{1, 3, 9, 9, 9}, per[5] = '{8, 36, 6, 0, 0};
  logic [7:0]  ad[3] = '{8'h04, 8'h0C, 8'h10};
  logic [31:0] mk[3] = '{32'h00FFFFFF, 32'h000000FF, 32'h000001FF};
  logic [31:0] rv[3] = '{32'h00030032, 32'h00000000, 32'h00000005};
  scsrg_top uut (.*);
  scsrg_clk_src_model gen_src (.ref_clk(ref_clk), .run(resetn), .half(8'h02), .clk_out(gen_clk_in));
  scsrg_clk_src_model ext_src (.ref_clk(ref_clk), .run(resetn), .half(ext_half), .clk_out(ext_clk_in));
  initial forever #50 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk) #1;
    {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk) #1;
    {reg_addr, reg_rd} = {a, 1'b1};
    exp_q.push_back(e);
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
  endtask
  task automatic conv(input logic e0, input logic e1);
    @(posedge ref_clk) #1;
    {conv_valid_g0, conv_valid_g1} = 2'h3;
    @(posedge ref_clk) #1;
    {conv_valid_g0, conv_valid_g1} = 2'h0;
    chk({30'h0, buf_wr_g0, buf_wr_g1}, {30'h0, e0, e1}, "buffer writes");
  endtask
  task automatic meas(output int pp, output int hh);
    int n;
    {pp, hh, n} = {32'h0, 32'h0, 32'h0};
    while (adc_clk !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
    while (adc_clk !== 1'b0 && n < 600) begin @(negedge ref_clk); n++; end
    while (adc_clk !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; pp++; end
    while (adc_clk !== 1'b0 && n < 600) begin @(negedge ref_clk); n++; pp++; hh++; end
  endtask
  // ----------------------------------------------------------------
  // read monitor
  // ----------------------------------------------------------------
  always @(posedge ref_clk) {rd_q, rd_q2} <= {reg_rd, rd_q};
  always @(negedge ref_clk) if (rd_q2) chk(reg_rdata, exp_q.pop_front(), "read");
  initial begin
    #3000000;
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 3; i++) rd(ad[i], rv[i]);
    rd(8'h20, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      h = 40 + d[15:8] % 161;
      g = h - d[7:0] % (h / 4 + 1);
      p = 1 + d[31:16] % 300;
      if (i == 0) d[23:0] = {h[11:0], g[11:0]};
      if (i == 2) d[8:0] = p[8:0];
      wr(ad[i], d);
      chk({31'h0, sync_start}, {31'h0, (d & mk[i]) != rv[i]}, "sync");
      rd(ad[i], d & mk[i]);
      if (i == 0) chk({8'h00, pll_ref_factor, pll_vco_factor}, d & mk[0], "pll");
    end
    $display("register test done");
    for (int c = 0; c < 16; c++) begin
      ok = (c == 0 || c == 4 || c == 5);
      wr(8'h0C, {24'h0, 4'h6, c[3:0]});
      repeat (2) @(negedge ref_clk);
      chk({30'h0, group0_enabled, source_invalid}, {30'h0, ok, !ok}, "group 0");
      chk({31'h0, group1_enabled}, 32'h0, "group 1");
      conv(ok, 1'b0);
    end
    wr(8'h0C, 32'h00000000);
    conv(1'b1, 1'b1);
    $display("source code test done");
    wr(8'h10, 32'h00000001);
    wr(8'h10, 32'h00000001);
    chk({31'h0, sync_start}, 32'h0, "sync on same value");
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk) #1;
      clock_target = (k == 2 || k == 4);
      wr(8'h10, nd[k]);
      wr(8'h0C, cd[k]);
      meas(p, h);
      meas(p, h);
      chk(p, per[k], "adc period");
      chk(h, per[k] / 2, "adc high time");
      chk({31'h0, $isunknown(adc_clk)}, 32'h0, "adc clock level");
    end
    $display("clock path test done");
    ext_half = 8'h01;
    wr(8'h0C, 32'h00000005);
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk) #1;
      high_speed_mode = !m[0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({30'h0, buf_reset, channels_settled}, 32'h2, "mode change");
      repeat (270) @(negedge ref_clk);
      chk({31'h0, channels_settled}, 32'h0, "early settle");
      repeat (20) @(negedge ref_clk);
      chk({30'h0, channels_settled, adc_hs_mode}, {30'h1, !m[0]}, "settled");
      g = 1;
      while (sample_strobe !== 1'b1 && g < 3000) begin @(negedge ref_clk); g++; end
      @(negedge ref_clk);
      for (g = 1; sample_strobe !== 1'b1 && g < 3000; g++) @(negedge ref_clk);
      chk(g, m[0] ? 1024 : 512, "sample interval");
    end
    $display("mode test done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
